/* File: rtl/cesr_pkg.sv */
package cesr_pkg;
   // Widths
   localparam int unsigned XLEN  = 32;
   localparam int unsigned CW    = 16;
   // Cause register fields
   localparam int unsigned NMF_HI = 31;
   localparam int unsigned NMF_LO = 16;
   localparam int unsigned MKF_HI = 15;
   localparam int unsigned MKF_LO = 0;
   localparam logic [31:0] CAUSE_RST = 32'h0000_0000;
   // Fixed cause codes
   localparam logic [15:0] CODE_NMI_A = 16'h0010;
   localparam logic [15:0] CODE_NMI_B = 16'h0020;
   localparam logic [15:0] CODE_NMI_C = 16'h0030;
   localparam logic [15:0] CODE_TRAP0 = 16'h0040;
   localparam logic [15:0] CODE_TRAP1 = 16'h0050;
   localparam logic [15:0] CODE_ILLOP = 16'h0060;
   localparam logic [15:0] CODE_DBTRP = 16'h0060;
   localparam logic [15:0] HI_ZERO    = 16'h0000;
   // Call-table base writable mask, bits 25..1
   localparam logic [31:0] CBASE_MASK = 32'h03FF_FFFE;
   // Register map, word offsets chosen locally
   localparam logic [3:0] REG_CAUSE  = 4'h0;
   localparam logic [3:0] REG_CBASE  = 4'h1;
   localparam logic [3:0] REG_MRET   = 4'h2;
   localparam logic [3:0] REG_NRET   = 4'h3;
   localparam logic [3:0] REG_STAT   = 4'h4;
   localparam logic [3:0] REG_MASK   = 4'h5;
   localparam logic [3:0] REG_LAST   = 4'h6;
   // Interrupt status bits
   localparam int unsigned NEV     = 2;
   localparam int unsigned EV_NMI  = 0;
   localparam int unsigned EV_MSK  = 1;
   // Entry source selector
   typedef enum logic [2:0]
   {
      SRC_NMI_A = 3'h0,
      SRC_NMI_B = 3'h1,
      SRC_NMI_C = 3'h2,
      SRC_MASK  = 3'h3,
      SRC_TRAP0 = 3'h4,
      SRC_TRAP1 = 3'h5,
      SRC_ILLOP = 3'h6,
      SRC_DBTRP = 3'h7
   } cesr_src_t;
   // Entry sequencer states
   typedef enum logic [2:0]
   {
      ST_RUN  = 3'b001,
      ST_SERV = 3'b010,
      ST_RET  = 3'b100
   } cesr_state_t;
endpackage : cesr_pkg

/* File: rtl/cesr_code_map.sv */
// Maps an entry source to its cause code and handler address; the maskable handler follows mask_code
module cesr_code_map
   import cesr_pkg::*;
(
   input  wire cesr_pkg::cesr_src_t src,
   input  wire logic [3:0]          trap_n,
   input  wire logic [15:0]         mask_code,
   output logic [15:0]              code,
   output logic [31:0]              handler,
   output logic                     is_nmi
);
   // Codes and handler addresses per source
   always_comb
   begin
      code    = CODE_ILLOP;
      handler = {HI_ZERO, CODE_ILLOP};
      is_nmi  = 1'b0;
      case (src)
         SRC_NMI_A:
         begin
            code    = CODE_NMI_A;
            handler = {HI_ZERO, CODE_NMI_A};
            is_nmi  = 1'b1;
         end
         SRC_NMI_B:
         begin
            code    = CODE_NMI_B;
            handler = {HI_ZERO, CODE_NMI_B};
            is_nmi  = 1'b1;
         end
         SRC_NMI_C:
         begin
            code    = CODE_NMI_C;
            handler = {HI_ZERO, CODE_NMI_C};
            is_nmi  = 1'b1;
         end
         SRC_MASK:
         begin
            code    = mask_code;
            handler = {HI_ZERO, mask_code};
         end
         SRC_TRAP0:
         begin
            code    = CODE_TRAP0 | {12'h000, trap_n};
            handler = {HI_ZERO, CODE_TRAP0};
         end
         SRC_TRAP1:
         begin
            code    = CODE_TRAP1 | {12'h000, trap_n};
            handler = {HI_ZERO, CODE_TRAP1};
         end
         SRC_ILLOP:
         begin
            code    = CODE_ILLOP;
            handler = {HI_ZERO, CODE_ILLOP};
         end
         SRC_DBTRP:
         begin
            code    = CODE_DBTRP;
            handler = {HI_ZERO, CODE_DBTRP};
         end
         default:
         begin
            code    = CODE_ILLOP;
            handler = {HI_ZERO, CODE_ILLOP};
         end
      endcase
   end
endmodule // cesr_code_map

/* File: rtl/cesr_recorder.sv */
module cesr_recorder
   import cesr_pkg::*;
#(
   parameter int unsigned AW = 32
)
(
   input  wire logic                clock,
   input  wire logic                rst,
   input  wire logic [3:0]          reg_addr,
   input  wire logic [31:0]         reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic [31:0]              reg_rdata,
   input  wire logic                entry_take,
   input  wire cesr_pkg::cesr_src_t entry_src,
   input  wire logic [3:0]          entry_trap_n,
   input  wire logic [15:0]         entry_mask_code,
   input  wire logic [AW-1:0]       cur_pc,
   input  wire logic [AW-1:0]       next_pc,
   input  wire logic                in_short_load,
   input  wire logic                in_divide,
   input  wire logic                in_frame_op,
   input  wire logic                frame_sp_done,
   input  wire logic                serv_done,
   input  wire logic [15:0]         table_offset,
   input  wire logic [15:0]         table_entry,
   output logic [31:0]              handler_addr,
   output logic                     handler_go,
   output logic                     abandon_instr,
   output logic [31:0]              resume_addr,
   output logic                     resume_go,
   output logic [31:0]              table_addr,
   output logic [31:0]              table_target,
   output logic                     irq
);
   import cesr_pkg::*;

   // Masks a call-table base to its writable bits
   function automatic logic [31:0] cbase_clean(input logic [31:0] v);
      cbase_clean = v & CBASE_MASK;
   endfunction

   logic [15:0] map_code;
   logic [31:0] map_handler;
   logic        map_nmi;

   cesr_code_map u_map
   (
      .src       (entry_src),
      .trap_n    (entry_trap_n),
      .mask_code (entry_mask_code),
      .code      (map_code),
      .handler   (map_handler),
      .is_nmi    (map_nmi)
   );

   logic [31:0]  cause_q, cause_d;
   logic [31:0]  cbase_q, cbase_d;
   logic [31:0]  mret_q, mret_d;
   logic [31:0]  nret_q, nret_d;
   logic [NEV-1:0] stat_q, stat_d;
   logic [NEV-1:0] mask_q, mask_d;
   logic         last_nmi_q, last_nmi_d;
   cesr_state_t  st_q, st_d;
   logic [31:0]  hand_q, hand_d;
   logic         hgo_q, hgo_d;
   logic         aban_q, aban_d;
   logic [31:0]  res_q, res_d;
   logic         rgo_q, rgo_d;
   logic [31:0]  tadr_q, tadr_d;
   logic [31:0]  ttgt_q, ttgt_d;
   logic [31:0]  rdata_q, rdata_d;
   logic         irq_q, irq_d;
   logic         restart;
   logic [31:0]  ret_pc;

   // Return address choice; restartable instructions save their own PC
   always_comb
   begin
      restart = in_short_load | in_divide |
                (in_frame_op & ~frame_sp_done);
      ret_pc  = 32'(restart ? cur_pc : next_pc);
   end

   // Entry recording, return registers and sequencing
   always_comb
   begin
      cause_d    = cause_q;
      mret_d     = mret_q;
      nret_d     = nret_q;
      last_nmi_d = last_nmi_q;
      st_d       = st_q;
      hand_d     = hand_q;
      hgo_d      = 1'b0;
      aban_d     = 1'b0;
      res_d      = res_q;
      rgo_d      = 1'b0;
      case (st_q)
         ST_RUN, ST_SERV:
         begin
            if (entry_take)
            begin
               if (map_nmi)
               begin
                  cause_d[NMF_HI:NMF_LO] = map_code;
                  nret_d = ret_pc;
               end
               else
               begin
                  cause_d[MKF_HI:MKF_LO] = map_code;
                  mret_d = ret_pc;
               end
               last_nmi_d = map_nmi;
               hand_d     = map_handler;
               hgo_d      = 1'b1;
               aban_d     = restart;
               st_d       = ST_SERV;
            end
            else if (st_q == ST_SERV && serv_done)
            begin
               st_d = ST_RET;
            end
         end
         ST_RET:
         begin
            res_d = last_nmi_q ? nret_q : mret_q;
            rgo_d = 1'b1;
            st_d  = ST_RUN;
         end
         default:
         begin
            st_d = ST_RUN;
         end
      endcase
   end

   // Register bus, call-table address, interrupt status
   always_comb
   begin
      cbase_d = cbase_q;
      mask_d  = mask_q;
      stat_d  = stat_q;
      rdata_d = 32'h0000_0000;
      if (reg_wr && reg_addr == REG_CBASE)
         cbase_d = cbase_clean(reg_wdata);
      if (reg_wr && reg_addr == REG_MASK)
         mask_d = reg_wdata[NEV-1:0];
      if (reg_wr && reg_addr == REG_STAT)
         stat_d = stat_q & ~reg_wdata[NEV-1:0];
      // Set wins over clear; an entry ignored in the return cycle sets none
      if (entry_take && map_nmi && st_q != ST_RET)
         stat_d[EV_NMI] = 1'b1;
      if (entry_take && !map_nmi && st_q != ST_RET)
         stat_d[EV_MSK] = 1'b1;
      if (reg_rd)
      begin
         case (reg_addr)
            REG_CAUSE: rdata_d = cause_q;
            REG_CBASE: rdata_d = cbase_clean(cbase_q);
            REG_MRET:  rdata_d = mret_q;
            REG_NRET:  rdata_d = nret_q;
            REG_STAT:  rdata_d = {30'h0, stat_q};
            REG_MASK:  rdata_d = {30'h0, mask_q};
            REG_LAST:  rdata_d = {31'h0, last_nmi_q};
            default:   rdata_d = 32'h0000_0000;
         endcase
      end
      tadr_d = cbase_q + {16'h0000, table_offset};
      ttgt_d = cbase_q + {16'h0000, table_entry};
      irq_d  = |(stat_d & mask_d);
   end

   // Base pointer has no reset; software loads it before use
   always_ff @(posedge clock)
   begin
      cbase_q <= cbase_d;
   end

   // State registers
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         cause_q    <= CAUSE_RST;
         mret_q     <= 32'h0000_0000;
         nret_q     <= 32'h0000_0000;
         last_nmi_q <= 1'b0;
         st_q       <= ST_RUN;
         hand_q     <= 32'h0000_0000;
         hgo_q      <= 1'b0;
         aban_q     <= 1'b0;
         res_q      <= 32'h0000_0000;
         rgo_q      <= 1'b0;
         stat_q     <= '0;
         mask_q     <= '0;
         tadr_q     <= 32'h0000_0000;
         ttgt_q     <= 32'h0000_0000;
         rdata_q    <= 32'h0000_0000;
         irq_q      <= 1'b0;
      end
      else
      begin
         cause_q    <= cause_d;
         mret_q     <= mret_d;
         nret_q     <= nret_d;
         last_nmi_q <= last_nmi_d;
         st_q       <= st_d;
         hand_q     <= hand_d;
         hgo_q      <= hgo_d;
         aban_q     <= aban_d;
         res_q      <= res_d;
         rgo_q      <= rgo_d;
         stat_q     <= stat_d;
         mask_q     <= mask_d;
         tadr_q     <= tadr_d;
         ttgt_q     <= ttgt_d;
         rdata_q    <= rdata_d;
         irq_q      <= irq_d;
      end
   end

   assign reg_rdata     = rdata_q;
   assign handler_addr  = hand_q;
   assign handler_go    = hgo_q;
   assign abandon_instr = aban_q;
   assign resume_addr   = res_q;
   assign resume_go     = rgo_q;
   assign table_addr    = tadr_q;
   assign table_target  = ttgt_q;
   assign irq           = irq_q;

   // Checks; one clock domain, all quiet while reset stands
   default clocking cb_chk @(posedge clock);
   endclocking
   default disable iff (rst);

   sequence s_nmi_take;
      entry_take && map_nmi;
   endsequence
   sequence s_msk_take;
      entry_take && !map_nmi;
   endsequence

   chk_cause_nmi_code: assert property (
      s_nmi_take |=> cause_q[NMF_HI:NMF_LO] == $past(map_code))
      else $error("nmi code not recorded");
   chk_nmi_field_kept: assert property (
      s_msk_take |=> $stable(cause_q[NMF_HI:NMF_LO]))
      else $error("nmi field changed by maskable entry");
   chk_msk_field_code: assert property (
      s_msk_take |=> cause_q[MKF_HI:MKF_LO] == $past(map_code))
      else $error("maskable code not recorded");
   // Reset is already low at the first free edge, so this one still runs
   chk_cause_reset_zero: assert property (
      $fell(rst) |-> cause_q == CAUSE_RST)
      else $error("cause not cleared by reset");
   chk_restart_own_pc: assert property (
      (s_msk_take and (in_divide || in_short_load)) |=>
      mret_q == $past(cur_pc) && abandon_instr)
      else $error("abandoned instruction pc wrong");
   chk_frame_before_sp: assert property (
      (s_nmi_take and (in_frame_op && !frame_sp_done)) |=>
      nret_q == $past(cur_pc) && abandon_instr)
      else $error("frame op before update must save own pc");
   chk_frame_after_sp: assert property (
      (s_nmi_take and (in_frame_op && frame_sp_done && !in_divide
       && !in_short_load)) |=> nret_q == $past(next_pc))
      else $error("frame op after update must save next pc");
   chk_next_pc_saved: assert property (
      (s_msk_take and !restart) |=> mret_q == $past(next_pc))
      else $error("next pc not saved");
   chk_resume_addr: assert property (
      (st_q == ST_SERV && serv_done && !entry_take) |=> ##1
      (resume_go && resume_addr == (last_nmi_q ? nret_q : mret_q)))
      else $error("resume address wrong");
   chk_cbase_fixed_zero: assert property (
      reg_rd && reg_addr == REG_CBASE |=> (reg_rdata & ~CBASE_MASK) == 32'h0)
      else $error("call base fixed bits not zero");
   chk_cbase_write_mask: assert property (
      reg_wr && reg_addr == REG_CBASE |=>
      cbase_q == ($past(reg_wdata) & CBASE_MASK))
      else $error("call base write not masked");
   chk_msk_handler: assert property (
      (entry_take && entry_src == SRC_MASK) |=>
      handler_go && handler_addr == {HI_ZERO, $past(entry_mask_code)})
      else $error("maskable handler address wrong");
   // NMI status bit sets on every non-maskable entry taken outside the return cycle, even beside a clear
   chk_nmi_stat_set: assert property (
      s_nmi_take |=> stat_q[EV_NMI])
      else $error("nmi status not set");
endmodule // cesr_recorder

/* File: testbench/cesr_pipe_model.sv */
// Pipeline and interrupt controller side, driven by tasks from the bench
module cesr_pipe_model
   import cesr_pkg::*;
(
   input  wire logic        clock,
   output logic             entry_take,
   output cesr_pkg::cesr_src_t entry_src,
   output logic [3:0]       entry_trap_n,
   output logic [15:0]      entry_mask_code,
   output logic [31:0]      cur_pc,
   output logic [31:0]      next_pc,
   output logic [3:0]       pipe_flags,
   output logic             serv_done,
   output logic [15:0]      table_offset,
   output logic [15:0]      table_entry
);
   timeunit 1ns;
   timeprecision 100ps;

   // Quiet pipeline at time zero
   initial
   begin
      entry_take = 1'b0;
      entry_src = SRC_NMI_A;
      entry_trap_n = 4'h0;
      entry_mask_code = 16'h0000;
      cur_pc = 32'h0000_0000;
      next_pc = 32'h0000_0004;
      pipe_flags = 4'h0;
      serv_done = 1'b0;
      table_offset = 16'h0000;
      table_entry = 16'h0000;
   end

   // One accepted entry; flags are short load, divide, frame op, sp done
   task automatic take(input logic [2:0] s, input logic [3:0] n,
                       input logic [15:0] c, input logic [3:0] f,
                       input logic [31:0] pc);
      @(posedge clock);
      entry_take <= 1'b1;
      entry_src <= cesr_src_t'(s);
      entry_trap_n <= n;
      entry_mask_code <= c;
      pipe_flags <= f;
      cur_pc <= pc;
      next_pc <= pc + 32'h0000_0004;
      @(posedge clock);
      entry_take <= 1'b0;
      // Released qualifiers flip so stale values cannot pass
      entry_trap_n <= ~n;
      entry_mask_code <= ~c;
   endtask

   // Return instruction ends servicing
   task automatic finish();
      @(posedge clock);
      serv_done <= 1'b1;
      @(posedge clock);
      serv_done <= 1'b0;
   endtask

   // Table-call operands
   task automatic call(input logic [15:0] o, input logic [15:0] e);
      @(posedge clock);
      table_offset <= o;
      table_entry <= e;
   endtask
endmodule // cesr_pipe_model

/* File: testbench/tb_top.sv */
`define CHK(nm, e, g) \
   begin compares++; if ((g) !== (e)) begin bad_count++; \
   $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import cesr_pkg::*;
   logic        clock, rst, reg_wr, reg_rd;
   logic [3:0]  reg_addr, entry_trap_n, pipe_flags;
   logic [31:0] reg_wdata, reg_rdata, cur_pc, next_pc, d, exp_cause;
   logic [31:0] handler_addr, resume_addr, table_addr, table_target;
   logic [31:0] ha, ra, pc;
   logic [15:0] entry_mask_code, table_offset, table_entry, ec, c;
   logic        entry_take, serv_done, handler_go, abandon_instr;
   logic        resume_go, irq, nm, own;
   logic [2:0]  s;
   logic [3:0]  f, n;
   cesr_src_t   entry_src;
   int          bad_count = 0;
   int          compares = 0;
   // Rows 8..10 cover restart cases on maskable and non-maskable entries, row 11 a frame op after its sp update
   logic [2:0]  r_src [12] = '{0, 1, 2, 3, 4, 5, 6, 7, 3, 3, 0, 1};
   logic [3:0]  r_fl [12] = '{0, 0, 0, 0, 0, 0, 0, 0, 8, 4, 2, 3};

   cesr_pipe_model pm (.clock(clock), .entry_take(entry_take),
      .entry_src(entry_src), .entry_trap_n(entry_trap_n),
      .entry_mask_code(entry_mask_code), .cur_pc(cur_pc),
      .next_pc(next_pc), .pipe_flags(pipe_flags), .serv_done(serv_done),
      .table_offset(table_offset), .table_entry(table_entry));

   cesr_recorder DUT (.clock(clock), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .entry_take(entry_take),
      .entry_src(entry_src), .entry_trap_n(entry_trap_n),
      .entry_mask_code(entry_mask_code), .cur_pc(cur_pc),
      .next_pc(next_pc), .in_short_load(pipe_flags[3]),
      .in_divide(pipe_flags[2]), .in_frame_op(pipe_flags[1]),
      .frame_sp_done(pipe_flags[0]), .serv_done(serv_done),
      .table_offset(table_offset), .table_entry(table_entry),
      .handler_addr(handler_addr), .handler_go(handler_go),
      .abandon_instr(abandon_instr), .resume_addr(resume_addr),
      .resume_go(resume_go), .table_addr(table_addr),
      .table_target(table_target), .irq(irq));

   // 250 MHz clock
   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   task automatic close_out();
      if (bad_count == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask

   // Interrupt level is registered from next status and mask, so it changes in the same cycle as they do
   task automatic irq_chk(input logic e);
      repeat (2) @(posedge clock);
      #1 `CHK("irq", e, irq)
   endtask

   // Generous bound; the full sequence needs well under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge clock);
      bad_count++;
      close_out();
   end

   // Main sequence
   initial
   begin
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0000_0000;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      rd(REG_CAUSE, d);
      `CHK("cause_rst", 32'h0000_0000, d)
      exp_cause = 32'h0000_0000;
      for (int i = 0; i < 12; i++)
      begin
         s = r_src[i];
         f = r_fl[i];
         n = 4'(i + 10);
         c = 16'h0100 + 16'(i) * 16'h0111;
         pc = 32'h0000_1000 + 32'(i) * 32'h0000_0100;
         nm = (s < 3'h3);
         own = f[3] | f[2] | (f[1] & ~f[0]);
         case (s)
            3'h0, 3'h1, 3'h2: ec = {9'h000, s + 3'h1, 4'h0};
            3'h3: ec = c;
            3'h4: ec = {12'h004, n};
            3'h5: ec = {12'h005, n};
            default: ec = 16'h0060;
         endcase
         ha = (s == 3'h4) ? 32'h0000_0040 :
              (s == 3'h5) ? 32'h0000_0050 : {16'h0000, ec};
         if (nm)
            exp_cause[31:16] = ec;
         else
            exp_cause[15:0] = ec;
         ra = own ? pc : pc + 32'h0000_0004;
         pm.take(s, n, c, f, pc);
         #1 `CHK("handler_go", 1'b1, handler_go)
         `CHK("handler_addr", ha, handler_addr)
         `CHK("abandon", own, abandon_instr)
         rd(REG_CAUSE, d);
         `CHK("cause", exp_cause, d)
         rd(nm ? REG_NRET : REG_MRET, d);
         `CHK("ret_addr", ra, d)
         rd(REG_LAST, d);
         `CHK("last_nmi", 32'(nm), d)
         pm.finish();
         @(posedge clock);
         #1 `CHK("resume_go", 1'b1, resume_go)
         `CHK("resume_addr", ra, resume_addr)
      end
      // Cause register ignores writes; unmapped place reads zero
      wr(REG_CAUSE, 32'hFFFF_FFFF);
      rd(REG_CAUSE, d);
      `CHK("cause_ro", exp_cause, d)
      wr(4'hF, 32'hFFFF_FFFF);
      rd(4'hF, d);
      `CHK("unmapped", 32'h0000_0000, d)
      // Both event kinds have fired; walk mask and clear
      rd(REG_STAT, d);
      `CHK("status", 32'h0000_0003, d)
      wr(REG_MASK, 32'h0000_0000);
      irq_chk(1'b0);
      wr(REG_MASK, 32'h0000_0001);
      irq_chk(1'b1);
      wr(REG_STAT, 32'h0000_0001);
      irq_chk(1'b0);
      rd(REG_STAT, d);
      `CHK("status_w1c", 32'h0000_0002, d)
      wr(REG_MASK, 32'h0000_0003);
      irq_chk(1'b1);
      wr(REG_STAT, 32'h0000_0002);
      irq_chk(1'b0);
      // Call-table base keeps only bits 25..1
      wr(REG_CBASE, 32'hFFFF_FFFF);
      rd(REG_CBASE, d);
      `CHK("cbase_ones", 32'h03FF_FFFE, d)
      wr(REG_CBASE, 32'hFC00_0001);
      rd(REG_CBASE, d);
      `CHK("cbase_fixed", 32'h0000_0000, d)
      wr(REG_CBASE, 32'h0123_4568);
      pm.call(16'h0024, 16'h7FFE);
      repeat (2) @(posedge clock);
      #1 `CHK("table_addr", 32'h0123_458C, table_addr)
      `CHK("table_target", 32'h0123_C566, table_target)
      // Second reset in mid-run clears the cause register again
      @(posedge clock);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      rd(REG_CAUSE, d);
      `CHK("cause_rst2", 32'h0000_0000, d)
      close_out();
   end
endmodule // tb_top
